// ===== scpd_data_areas.sv
// Our own choice: the AXI4-Lite register port.
`timescale 1ns/100ps
// What this block does
// (R1) End code 00: monitor gets component response code; 0000 is normal.
// (R2) Codes 0401 unsupported, 1001 too long, 1002 too short are kept.
// (R3) Codes 1101 area, 1103 start address, 1104 end address are kept.
// (R4) Codes 1003, 110B, 1100, 3003, 2203 are kept as reported.
// (R5) End code not 00: monitor holds error code; FF high byte is send error.
// (R6) Send errors FF04, FF0D, FF14, FF15, FF16, FF18 are kept.
// (R7) Line errors FF10 to FF13 and FF97 are kept.
// (R8) Non-volatile write failure FF21 is kept during writes.
// (R9) No answer at all records the timeout code in the monitor.
// (R10) Software puts command in bits 15:8, related info in bits 7:0.
// (R11) Command word 0600 means no set_value is written in that scan.
// (R12) Software selects RAM-write and backup modes in one scan only.
// (R13) Variable n: low half at word 2n, high half at word 2n+1.
// (R14) A failed write stops; earlier variables stay, later ones are skipped.
// (R15) A failed write sequence never executes the operation command.
// (R16) The write area is 26 words: monitor, command, twelve pairs.
// (R17) The temperature read area always takes 11 words.
// (R18) Groups read monitor, temperature, status, target; more per group.
// (R19) Groups 5 to 7 read heater current into +9 and its status +10.
// (R20) Each read word is a raw 16-bit two's complement value.
// (R21) A failed item reads 0000, monitor gets the code, earlier items stay.
// (R22) Both areas use the same monitor word structure.
// (R23) Software tracks decimal point and BCD format itself.
// (R24) The failing item and all later items are cleared to zero.
// (R25) One device is finished or abandoned before the next is served.
module scpd_data_areas #(
	// Value is arbitrary; no timeout code is defined for the component.
	parameter logic [15:0] TIMEOUT_CODE = 16'hFFFF
) (
	// Clock and reset
	input  wire logic                 clk,
	input  wire logic                 rst_n,
	// AXI4-Lite slave
	input  wire logic [7:0]           s_axi_awaddr,
	input  wire logic                 s_axi_awvalid,
	output logic                      s_axi_awready,
	input  wire logic [31:0]          s_axi_wdata,
	input  wire logic [3:0]           s_axi_wstrb,
	input  wire logic                 s_axi_wvalid,
	output logic                      s_axi_wready,
	output logic [1:0]                s_axi_bresp,
	output logic                      s_axi_bvalid,
	input  wire logic                 s_axi_bready,
	input  wire logic [7:0]           s_axi_araddr,
	input  wire logic                 s_axi_arvalid,
	output logic                      s_axi_arready,
	output logic [31:0]               s_axi_rdata,
	output logic [1:0]                s_axi_rresp,
	output logic                      s_axi_rvalid,
	input  wire logic                 s_axi_rready,
	// Serial engine side
	output logic                      link_req_valid,
	output scpd_pkg::scpd_req_t       link_req,
	input  wire logic                 link_req_ready,
	input  wire logic                 link_rsp_valid,
	input  wire scpd_pkg::scpd_rsp_t  link_rsp,
	// Status
	output logic                      scan_busy
);

	// ------------------------------------------------------------------
	// Storage
	// ------------------------------------------------------------------
	logic [15:0]           wr_q [1:scpd_pkg::WR_WORDS-1];
	logic [15:0]           rd_q [1:scpd_pkg::RD_WORDS-1];
	logic [15:0]           wr_mon_q;
	logic [15:0]           rd_mon_q;
	logic [3:0]            nvar_q;
	logic [2:0]            group_q;
	logic                  start_q;
	scpd_pkg::scpd_state_t state_q;
	logic [3:0]            var_q;
	logic [3:0]            item_q;
	logic [15:0]           cmd_q;
	logic                  wait_q;
	logic                  req_valid_q;
	scpd_pkg::scpd_req_t   req_q;
	scpd_pkg::scpd_req_t   req_d;
	logic                  busy_q;
	logic                  unknown_q;

	logic                  aw_full_q;
	logic                  w_full_q;
	logic [5:0]            aw_idx_q;
	logic [31:0]           wdata_q;
	logic [3:0]            wstrb_q;
	logic                  awready_q;
	logic                  wready_q;
	logic                  bvalid_q;
	logic [1:0]            bresp_q;
	logic                  arready_q;
	logic                  rvalid_q;
	logic [31:0]           rdata_q;
	logic [1:0]            rresp_q;
	logic [31:0]           rd_word;

	logic                  do_write;
	logic                  rsp_take;
	logic                  rsp_err;
	logic [15:0]           mon_val;
	logic [3:0]            nvar_eff;
	logic [3:0]            last_item;
	logic                  issue;
	logic [4:0]            lo_idx;
	logic [4:0]            hi_idx;
	logic [5:0]            ar_idx;

	function automatic logic idx_mapped(input logic [5:0] i);
		return (i < 6'(scpd_pkg::WR_WORDS)) ||
			(i >= scpd_pkg::IDX_RD_BASE &&
			 i < scpd_pkg::IDX_RD_BASE + 6'(scpd_pkg::RD_WORDS)) ||
			i == scpd_pkg::IDX_CTRL || i == scpd_pkg::IDX_STAT;
	endfunction

	function automatic logic code_known(input logic [15:0] c);
		case (c)
			scpd_pkg::RC_OK, scpd_pkg::RC_UNSUP, scpd_pkg::RC_LONG,
			scpd_pkg::RC_SHORT, scpd_pkg::RC_AREA, scpd_pkg::RC_START,
			scpd_pkg::RC_END, scpd_pkg::RC_COUNT, scpd_pkg::RC_RSPLONG,
			scpd_pkg::RC_PARAM, scpd_pkg::RC_RDONLY, scpd_pkg::RC_OPER,
			scpd_pkg::EC_ADDR, scpd_pkg::EC_NOEXEC, scpd_pkg::EC_PARITY,
			scpd_pkg::EC_FRAME, scpd_pkg::EC_OVERRUN, scpd_pkg::EC_CHECK,
			scpd_pkg::EC_FORMAT, scpd_pkg::EC_NUMERIC, scpd_pkg::EC_SUBADDR,
			scpd_pkg::EC_LENGTH, scpd_pkg::EC_NVMEM, scpd_pkg::EC_RSPCHECK:
				return 1'b1;
			default:
				return 1'b0;
		endcase
	endfunction

	function automatic logic [3:0] group_last(input logic [2:0] g);
		if (g >= scpd_pkg::GRP_HEATER)
			return scpd_pkg::LAST_HEATER;
		else if (g == scpd_pkg::GRP_PID)
			return scpd_pkg::LAST_PID;
		else if (g == scpd_pkg::GRP_ALARM)
			return scpd_pkg::LAST_ALARM;
		return scpd_pkg::LAST_BASIC;
	endfunction

	// ------------------------------------------------------------------
	// AXI4-Lite write path
	// ------------------------------------------------------------------
	assign do_write = aw_full_q & w_full_q & ~bvalid_q;

	always_ff @(posedge clk) begin
		if (!rst_n) begin
			aw_full_q <= 1'b0;
			awready_q <= 1'b0;
			aw_idx_q  <= 6'h00;
		end else if (s_axi_awvalid && awready_q) begin
			aw_full_q <= 1'b1;
			awready_q <= 1'b0;
			aw_idx_q  <= s_axi_awaddr[7:2];
		end else if (do_write) begin
			aw_full_q <= 1'b0;
		end else if (!aw_full_q && !bvalid_q) begin
			awready_q <= 1'b1;
		end
	end

	always_ff @(posedge clk) begin
		if (!rst_n) begin
			w_full_q <= 1'b0;
			wready_q <= 1'b0;
			wdata_q  <= 32'h0000_0000;
			wstrb_q  <= 4'h0;
		end else if (s_axi_wvalid && wready_q) begin
			w_full_q <= 1'b1;
			wready_q <= 1'b0;
			wdata_q  <= s_axi_wdata;
			wstrb_q  <= s_axi_wstrb;
		end else if (do_write) begin
			w_full_q <= 1'b0;
		end else if (!w_full_q && !bvalid_q) begin
			wready_q <= 1'b1;
		end
	end

	always_ff @(posedge clk) begin
		if (!rst_n) begin
			bvalid_q <= 1'b0;
			bresp_q  <= scpd_pkg::AXI_OKAY;
		end else if (do_write) begin
			bvalid_q <= 1'b1;
			bresp_q  <= idx_mapped(aw_idx_q) ? scpd_pkg::AXI_OKAY :
				scpd_pkg::AXI_SLVERR;
		end else if (s_axi_bready) begin
			bvalid_q <= 1'b0;
		end
	end

	// Write area words 1..25; word 0 is the monitor and stays read-only.
	// The monitors live elsewhere; software writes to them are dropped.
	for (genvar gi = 1; gi < scpd_pkg::WR_WORDS; gi++) begin : g_wr // R16
		always_ff @(posedge clk) begin
			if (!rst_n) begin
				wr_q[gi] <= scpd_pkg::WORD_RST;
			end else if (do_write && aw_idx_q == 6'(gi)) begin
				if (wstrb_q[0])
					wr_q[gi][7:0] <= wdata_q[7:0];
				if (wstrb_q[1])
					wr_q[gi][15:8] <= wdata_q[15:8];
			end
		end
	end

	always_ff @(posedge clk) begin
		if (!rst_n) begin
			nvar_q  <= scpd_pkg::NVAR_RST;
			group_q <= scpd_pkg::GROUP_RST;
			start_q <= 1'b0;
		end else begin
			start_q <= 1'b0;
			if (do_write && aw_idx_q == scpd_pkg::IDX_CTRL) begin
				if (wstrb_q[0])
					start_q <= wdata_q[scpd_pkg::CTRL_START_BIT] &&
						state_q == scpd_pkg::ST_IDLE;
				if (wstrb_q[1])
					nvar_q <= wdata_q[scpd_pkg::CTRL_NVAR_LSB +: 4];
				if (wstrb_q[2])
					group_q <= wdata_q[scpd_pkg::CTRL_GROUP_LSB +: 3];
			end
		end
	end

	// ------------------------------------------------------------------
	// AXI4-Lite read path
	// ------------------------------------------------------------------
	assign ar_idx = s_axi_araddr[7:2];

	always_comb begin
		rd_word = 32'h0000_0000;
		if (ar_idx == scpd_pkg::IDX_WR_MONITOR)
			rd_word[15:0] = wr_mon_q;
		else if (ar_idx < 6'(scpd_pkg::WR_WORDS))
			rd_word[15:0] = wr_q[ar_idx[4:0]];
		else if (ar_idx == scpd_pkg::IDX_RD_BASE)
			rd_word[15:0] = rd_mon_q;
		else if (ar_idx > scpd_pkg::IDX_RD_BASE &&
			ar_idx < scpd_pkg::IDX_RD_BASE + 6'(scpd_pkg::RD_WORDS))
			rd_word[15:0] = rd_q[4'(ar_idx - scpd_pkg::IDX_RD_BASE)];
		else if (ar_idx == scpd_pkg::IDX_CTRL)
			rd_word = {13'h0000, group_q, 4'h0, nvar_q, 8'h00};
		else if (ar_idx == scpd_pkg::IDX_STAT)
			rd_word = {28'h000_0000, unknown_q, state_q, busy_q};
	end

	always_ff @(posedge clk) begin
		if (!rst_n) begin
			arready_q <= 1'b0;
			rvalid_q  <= 1'b0;
			rdata_q   <= 32'h0000_0000;
			rresp_q   <= scpd_pkg::AXI_OKAY;
		end else if (s_axi_arvalid && arready_q) begin
			arready_q <= 1'b0;
			rvalid_q  <= 1'b1;
			rdata_q   <= rd_word;
			rresp_q   <= idx_mapped(ar_idx) ? scpd_pkg::AXI_OKAY :
				scpd_pkg::AXI_SLVERR;
		end else if (rvalid_q && s_axi_rready) begin
			rvalid_q <= 1'b0;
		end else if (!rvalid_q) begin
			arready_q <= 1'b1;
		end
	end

	// ------------------------------------------------------------------
	// Scan sequencer
	// ------------------------------------------------------------------
	assign rsp_take = wait_q & link_rsp_valid;
	assign rsp_err = link_rsp.timeout |
		(link_rsp.end_code != scpd_pkg::END_OK) |
		(link_rsp.code != scpd_pkg::RC_OK);
	// Same monitor encoding serves the write and the read area.
	assign mon_val = link_rsp.timeout ? TIMEOUT_CODE : link_rsp.code; // R1 R5 R9 R22
	assign nvar_eff = (nvar_q > scpd_pkg::MAX_VARS) ? scpd_pkg::MAX_VARS :
		nvar_q;
	assign last_item = group_last(group_q); // R18 R19
	assign issue = state_q != scpd_pkg::ST_IDLE && !req_valid_q && !wait_q;
	assign lo_idx = {var_q, 1'b0}; // R13
	assign hi_idx = {var_q, 1'b1}; // R13

	always_comb begin
		req_d = '0;
		unique case (state_q)
			scpd_pkg::ST_IDLE: begin
				req_d = '0;
			end
			scpd_pkg::ST_WVAR: begin
				req_d.op   = scpd_pkg::OP_WR_VAR;
				req_d.dev  = scpd_pkg::DEV_WRITE;
				req_d.idx  = {1'b0, var_q};
				req_d.data = {wr_q[hi_idx], wr_q[lo_idx]}; // R13
			end
			scpd_pkg::ST_WCMD: begin
				req_d.op   = scpd_pkg::OP_EXEC;
				req_d.dev  = scpd_pkg::DEV_WRITE;
				req_d.data = {16'h0000, cmd_q};
			end
			scpd_pkg::ST_RITEM: begin
				req_d.op  = scpd_pkg::OP_RD_ITEM;
				req_d.dev = scpd_pkg::DEV_READ;
				req_d.idx = {1'b0, item_q};
			end
		endcase
	end

	// One request at a time: nothing new is issued until the answer is in.
	always_ff @(posedge clk) begin
		if (!rst_n) begin
			req_valid_q <= 1'b0;
			req_q       <= '0;
			wait_q      <= 1'b0;
		end else begin
			if (rsp_take)
				wait_q <= 1'b0;
			else if (req_valid_q && link_req_ready)
				wait_q <= 1'b1;
			if (req_valid_q && link_req_ready) begin
				req_valid_q <= 1'b0;
			end else if (issue) begin
				req_valid_q <= 1'b1; // R25
				req_q       <= req_d;
			end
		end
	end

	always_ff @(posedge clk) begin
		if (!rst_n) begin
			state_q  <= scpd_pkg::ST_IDLE;
			var_q    <= 4'h1;
			item_q   <= 4'h1;
			cmd_q    <= scpd_pkg::WORD_RST;
			busy_q   <= 1'b0;
			wr_mon_q <= scpd_pkg::WORD_RST;
			rd_mon_q <= scpd_pkg::WORD_RST;
		end else begin
			unique case (state_q)
				scpd_pkg::ST_IDLE: begin
					if (start_q) begin
						cmd_q  <= wr_q[1];
						var_q  <= 4'h1;
						item_q <= 4'h1;
						busy_q <= 1'b1;
						if (wr_q[1] == scpd_pkg::CMD_NO_SV || nvar_eff == 4'h0)
							state_q <= scpd_pkg::ST_WCMD; // R11
						else
							state_q <= scpd_pkg::ST_WVAR;
					end
				end
				scpd_pkg::ST_WVAR: begin
					if (rsp_take && rsp_err) begin
						wr_mon_q <= mon_val; // R5 R8 R9
						state_q  <= scpd_pkg::ST_RITEM; // R14 R15 R25
					end else if (rsp_take && var_q == nvar_eff) begin
						state_q <= scpd_pkg::ST_WCMD;
					end else if (rsp_take) begin
						var_q <= var_q + 4'h1;
					end
				end
				scpd_pkg::ST_WCMD: begin
					if (rsp_take) begin
						wr_mon_q <= mon_val; // R1
						state_q  <= scpd_pkg::ST_RITEM; // R25
					end
				end
				scpd_pkg::ST_RITEM: begin
					if (rsp_take && (rsp_err || item_q >= last_item)) begin
						rd_mon_q <= mon_val; // R21 R22
						busy_q   <= 1'b0;
						state_q  <= scpd_pkg::ST_IDLE;
					end else if (rsp_take) begin
						item_q <= item_q + 4'h1;
					end
				end
			endcase
		end
	end

	// Read area words +1..+10. Stale words outside the chosen group stay until an item fails.
	for (genvar gi = 1; gi < scpd_pkg::RD_WORDS; gi++) begin : g_rd // R17
		always_ff @(posedge clk) begin
			if (!rst_n) begin
				rd_q[gi] <= scpd_pkg::WORD_RST;
			end else if (rsp_take && state_q == scpd_pkg::ST_RITEM) begin
				if (!rsp_err && item_q == 4'(gi))
					rd_q[gi] <= link_rsp.data; // R20
				else if (rsp_err && 4'(gi) >= item_q)
					rd_q[gi] <= scpd_pkg::WORD_RST; // R21 R24
			end
		end
	end

	// Flags an answer outside the known code table for software triage.
	always_ff @(posedge clk) begin
		if (!rst_n)
			unknown_q <= 1'b0;
		else if (rsp_take)
			unknown_q <= !link_rsp.timeout && !code_known(link_rsp.code); // R2 R3 R4 R6 R7 R8
	end

	assign s_axi_awready  = awready_q;
	assign s_axi_wready   = wready_q;
	assign s_axi_bvalid   = bvalid_q;
	assign s_axi_bresp    = bresp_q;
	assign s_axi_arready  = arready_q;
	assign s_axi_rvalid   = rvalid_q;
	assign s_axi_rdata    = rdata_q;
	assign s_axi_rresp    = rresp_q;
	assign link_req_valid = req_valid_q;
	assign link_req       = req_q;
	assign scan_busy      = busy_q;

	// ------------------------------------------------------------------
	// Assertions
	// ------------------------------------------------------------------
	default clocking cb @(posedge clk); endclocking
	default disable iff (!rst_n);

	sequence s_var_fail;
		state_q == scpd_pkg::ST_WVAR && rsp_take && rsp_err;
	endsequence

	sequence s_item_fail;
		state_q == scpd_pkg::ST_RITEM && rsp_take && rsp_err;
	endsequence

	a_no_sv_scan: assert property (link_req_valid && // R11
		link_req.op == scpd_pkg::OP_WR_VAR |-> cmd_q != scpd_pkg::CMD_NO_SV)
		else $error("set_value sent in a 0600 scan");
	a_abort_skip: assert property (s_var_fail |=> // R14 R15
		state_q == scpd_pkg::ST_RITEM ##0 !link_req_valid ##1
		link_req.op == scpd_pkg::OP_RD_ITEM)
		else $error("failed write did not skip to next device");
	a_fail_mon: assert property (s_var_fail |=> // R5 R9
		wr_mon_q == ($past(link_rsp.timeout) ? TIMEOUT_CODE :
		$past(link_rsp.code)))
		else $error("write monitor lacks the failure code");
	a_ok_mon: assert property (state_q == scpd_pkg::ST_WCMD && rsp_take && // R1
		!rsp_err |=> wr_mon_q == scpd_pkg::RC_OK)
		else $error("normal completion not 0000");
	a_pair_data: assert property (issue && // R13
		state_q == scpd_pkg::ST_WVAR |=>
		link_req.data == $past({wr_q[hi_idx], wr_q[lo_idx]}))
		else $error("set_value halves misplaced");
	a_item_zero: assert property (s_item_fail |=> // R24 R21
		rd_q[scpd_pkg::RD_WORDS-1] == scpd_pkg::WORD_RST &&
		rd_mon_q == $past(mon_val))
		else $error("failed read did not clear later items");
	a_item_keep: assert property (s_item_fail ##0 item_q > 4'h1 |=> // R21
		rd_q[1] == $past(rd_q[1]))
		else $error("earlier read item was disturbed");
	a_group_len: assert property (link_req_valid && // R18 R19
		link_req.op == scpd_pkg::OP_RD_ITEM |-> link_req.idx[3:0] <= last_item
		&& link_req.idx[3:0] >= 4'h1)
		else $error("read item outside chosen group");
	a_one_pend: assert property (link_req_valid && !link_req_ready |=> // R25
		link_req_valid && $stable(link_req) && !wait_q)
		else $error("request dropped or changed while pending");

endmodule

// ===== scpd_link_model.sv
`timescale 1ns/100ps
module scpd_link_model (
	// Clock and reset
	input  wire logic                clk,
	input  wire logic                rst_n,
	// Requests from the block
	input  wire logic                link_req_valid,
	input  wire scpd_pkg::scpd_req_t link_req,
	output logic                     link_req_ready,
	// Answers to the block
	output logic                     link_rsp_valid,
	output scpd_pkg::scpd_rsp_t      link_rsp,
	// Fault control from the bench
	input  wire logic [7:0]          fail_at,
	input  wire scpd_pkg::scpd_rsp_t fail_rsp,
	input  wire logic                slow,
	output logic [7:0]               req_count
);
	scpd_pkg::scpd_req_t log_q [256];
	logic [3:0]          wait_q;

	// The answer word is inverted between answers, so a block that reads it
	// outside the pulse sees a changing value instead of the last answer.
	always @(posedge clk) begin
		link_req_ready <= 1'b0;
		link_rsp_valid <= 1'b0;
		link_rsp <= ~link_rsp;
		if (!rst_n) begin
			wait_q <= 4'h0;
			req_count <= 8'h00;
			link_rsp <= '0;
		end else if (wait_q != 4'h0) begin
			wait_q <= wait_q - 4'h1;
			if (wait_q == 4'h1) begin
				link_rsp_valid <= 1'b1;
				link_rsp <= (req_count == fail_at) ? fail_rsp :
					{8'h00, 16'h0000,
					16'hF000 | {11'h000, log_q[req_count].idx}, 1'b0};
				req_count <= req_count + 8'h01;
			end
		end else if (link_req_valid && !link_req_ready) begin
			link_req_ready <= 1'b1;
			log_q[req_count] <= link_req;
			wait_q <= slow ? 4'h9 : 4'h2;
		end
	end
endmodule

// ===== scpd_pkg.sv
package scpd_pkg;

	// ------------------------------------------------------------------
	// Register map, word indices (byte address is four times the index)
	// ------------------------------------------------------------------
	localparam logic [5:0] IDX_WR_MONITOR   = 6'h00;
	localparam logic [5:0] IDX_WR_COMMAND   = 6'h01;
	localparam logic [5:0] IDX_VAR11_LOW    = 6'h16;
	localparam logic [5:0] IDX_VAR11_HIGH   = 6'h17;
	localparam logic [5:0] IDX_VAR12_LOW    = 6'h18;
	localparam logic [5:0] IDX_VAR12_HIGH   = 6'h19;
	localparam logic [5:0] IDX_RD_BASE      = 6'h20;
	localparam logic [5:0] IDX_CTRL         = 6'h30;
	localparam logic [5:0] IDX_STAT         = 6'h31;
	localparam int         WR_WORDS         = 26;
	localparam int         RD_WORDS         = 11;
	localparam logic [3:0] MAX_VARS         = 4'hC;

	// ------------------------------------------------------------------
	// Control word fields and reset values
	// ------------------------------------------------------------------
	localparam int          CTRL_START_BIT  = 0;
	localparam int          CTRL_NVAR_LSB   = 8;
	localparam int          CTRL_GROUP_LSB  = 16;
	localparam logic [3:0]  NVAR_RST        = 4'hC;
	localparam logic [2:0]  GROUP_RST       = 3'h1;
	localparam logic [15:0] WORD_RST        = 16'h0000;
	localparam logic [2:0]  GRP_ALARM       = 3'h3;
	localparam logic [2:0]  GRP_PID         = 3'h4;
	localparam logic [2:0]  GRP_HEATER      = 3'h5;
	localparam logic [3:0]  LAST_BASIC      = 4'h3;
	localparam logic [3:0]  LAST_ALARM      = 4'h5;
	localparam logic [3:0]  LAST_PID        = 4'h8;
	localparam logic [3:0]  LAST_HEATER     = 4'hA;

	// ------------------------------------------------------------------
	// Component answer codes
	// ------------------------------------------------------------------
	localparam logic [7:0]  END_OK     = 8'h00;
	localparam logic [15:0] CMD_NO_SV  = 16'h0600;
	localparam logic [15:0] RC_OK      = 16'h0000, RC_UNSUP = 16'h0401,
		RC_LONG = 16'h1001, RC_SHORT = 16'h1002, RC_AREA = 16'h1101,
		RC_START = 16'h1103, RC_END = 16'h1104, RC_COUNT = 16'h1003,
		RC_RSPLONG = 16'h110B, RC_PARAM = 16'h1100, RC_RDONLY = 16'h3003,
		RC_OPER = 16'h2203;
	localparam logic [15:0] EC_ADDR = 16'hFF04, EC_NOEXEC = 16'hFF0D,
		EC_PARITY = 16'hFF10, EC_FRAME = 16'hFF11, EC_OVERRUN = 16'hFF12,
		EC_CHECK = 16'hFF13, EC_FORMAT = 16'hFF14, EC_NUMERIC = 16'hFF15,
		EC_SUBADDR = 16'hFF16, EC_LENGTH = 16'hFF18, EC_NVMEM = 16'hFF21,
		EC_RSPCHECK = 16'hFF97;

	localparam logic [1:0] AXI_OKAY   = 2'b00;
	localparam logic [1:0] AXI_SLVERR = 2'b10;

	// ------------------------------------------------------------------
	// Types
	// ------------------------------------------------------------------
	typedef enum logic [1:0] {
		ST_IDLE  = 2'b00,
		ST_WVAR  = 2'b01,
		ST_WCMD  = 2'b11,
		ST_RITEM = 2'b10
	} scpd_state_t;

	typedef enum logic [1:0] {
		OP_WR_VAR  = 2'b00,
		OP_EXEC    = 2'b01,
		OP_RD_ITEM = 2'b10
	} scpd_op_t;

	localparam logic DEV_WRITE = 1'b0;
	localparam logic DEV_READ  = 1'b1;

	typedef struct packed {
		scpd_op_t    op;
		logic        dev;
		logic [4:0]  idx;
		logic [31:0] data;
	} scpd_req_t;

	typedef struct packed {
		logic [7:0]  end_code;
		logic [15:0] code;
		logic [15:0] data;
		logic        timeout;
	} scpd_rsp_t;

endpackage

// ===== testbench.sv
`timescale 1ns/100ps
module testbench;
	// ----------------------------------------------------------------
	// Signals
	// ----------------------------------------------------------------
	logic                clk = 1'b0, rst_n = 1'b0, slow = 1'b0;
	logic [7:0]          awaddr = 8'h00, araddr = 8'h00;
	logic                awvalid = 1'b0, wvalid = 1'b0, bready = 1'b0;
	logic                arvalid = 1'b0, rready = 1'b0;
	logic [31:0]         wdata = 32'h0000_0000, rdata, rdv;
	logic                awready, wready, bvalid, arready, rvalid, busy;
	logic [1:0]          bresp, rresp, br;
	logic                lq_v, lq_r, ls_v;
	logic [7:0]          fail_at = 8'hFF, cnt, base;
	scpd_pkg::scpd_req_t lq;
	scpd_pkg::scpd_rsp_t ls, frsp = '0;
	int                  errors = 0, check_count = 0;
	logic [15:0]         codes [23] = '{16'h0401, 16'h1001, 16'h1002,
		16'h1101, 16'h1103, 16'h1104, 16'h1003, 16'h110B, 16'h1100,
		16'h3003, 16'h2203, 16'hFF04, 16'hFF0D, 16'hFF10, 16'hFF11,
		16'hFF12, 16'hFF13, 16'hFF14, 16'hFF15, 16'hFF16, 16'hFF18,
		16'hFF21, 16'hFF97};

	always #12.5 clk = ~clk;

	scpd_data_areas u_dut (.clk(clk), .rst_n(rst_n), .s_axi_awaddr(awaddr),
		.s_axi_awvalid(awvalid), .s_axi_awready(awready),
		.s_axi_wdata(wdata), .s_axi_wstrb(4'hF), .s_axi_wvalid(wvalid),
		.s_axi_wready(wready), .s_axi_bresp(bresp), .s_axi_bvalid(bvalid),
		.s_axi_bready(bready), .s_axi_araddr(araddr),
		.s_axi_arvalid(arvalid), .s_axi_arready(arready),
		.s_axi_rdata(rdata), .s_axi_rresp(rresp), .s_axi_rvalid(rvalid),
		.s_axi_rready(rready), .link_req_valid(lq_v), .link_req(lq),
		.link_req_ready(lq_r), .link_rsp_valid(ls_v), .link_rsp(ls),
		.scan_busy(busy));

	scpd_link_model u_link (.clk(clk), .rst_n(rst_n), .link_req_valid(lq_v),
		.link_req(lq), .link_req_ready(lq_r), .link_rsp_valid(ls_v),
		.link_rsp(ls), .fail_at(fail_at), .fail_rsp(frsp), .slow(slow),
		.req_count(cnt));

	// ----------------------------------------------------------------
	// Tasks
	// ----------------------------------------------------------------
	task automatic chk(input string nm, input logic [39:0] seen, exp);
		check_count++;
		if (seen !== exp) begin
			errors++;
			$display("ERROR %s expected %h seen %h", nm, exp, seen);
		end
	endtask

	task automatic wr(input logic [5:0] i, input logic [31:0] d);
		@(posedge clk);
		awaddr <= {i, 2'b00};
		wdata <= d;
		awvalid <= 1'b1;
		wvalid <= 1'b1;
		bready <= 1'b1;
		do begin
			@(posedge clk);
			if (awready) awvalid <= 1'b0;
			if (wready) wvalid <= 1'b0;
		end while (!bvalid);
		br = bresp;
		bready <= 1'b0;
	endtask

	task automatic rd(input logic [5:0] i, input logic [31:0] exp);
		@(posedge clk);
		araddr <= {i, 2'b00};
		arvalid <= 1'b1;
		rready <= 1'b1;
		do begin
			@(posedge clk);
			if (arready) arvalid <= 1'b0;
		end while (!rvalid);
		rdv = rdata;
		br = rresp;
		rready <= 1'b0;
		chk($sformatf("word %h", i), rdv, exp);
	endtask

	task automatic scan(input logic [31:0] c);
		int t = 0;
		base = cnt;
		wr(scpd_pkg::IDX_CTRL, c);
		while (!busy && t < 20) begin
			@(posedge clk);
			t++;
		end
		chk("scan busy", busy, 1);
		while (busy) @(posedge clk);
	endtask

	task automatic summarize();
		if (errors == 0 && check_count > 0) begin
			$display("== PASSED ==");
		end else begin
			$display("== FAILED ==");
		end
		$finish;
	endtask

	// ----------------------------------------------------------------
	// Tests
	// ----------------------------------------------------------------
	initial begin
		repeat (3) @(posedge clk);
		rst_n <= 1'b1;
		repeat (3) @(posedge clk);
		rd(scpd_pkg::IDX_CTRL, 32'h0001_0C00);
		rd(6'h16, 32'h0000_0000);
		rd(6'h3F, 32'h0000_0000);
		chk("unmapped rresp", br, scpd_pkg::AXI_SLVERR);
		wr(6'h00, 32'h0000_1234);
		chk("monitor bresp", br, scpd_pkg::AXI_OKAY);
		rd(6'h00, 32'h0000_0000);
		for (int n = 1; n <= 12; n++) begin
			wr(6'(2 * n), {16'h0000, 16'h1000 + 16'(n)});
			wr(6'(2 * n + 1), {16'h0000, 16'h2000 + 16'(n)});
		end
		rd(6'h19, 32'h0000_200C);
		wr(6'h01, 32'h0000_0102);
		scan(32'h0005_0301);
		chk("requests", cnt - base, 14);
		for (int n = 1; n <= 3; n++)
			chk("var req", u_link.log_q[base + 8'(n - 1)], {scpd_pkg::OP_WR_VAR,
				scpd_pkg::DEV_WRITE, 5'(n), 16'h2000 + 16'(n),
				16'h1000 + 16'(n)});
		chk("exec req", u_link.log_q[base + 8'h03], {scpd_pkg::OP_EXEC,
			scpd_pkg::DEV_WRITE, 5'h00, 32'h0000_0102});
		for (int k = 1; k <= 10; k++)
			rd(6'h20 + 6'(k), {16'h0000, 16'hF000 + 16'(k)});
		rd(6'h20, 32'h0000_0000);
		rd(6'h00, 32'h0000_0000);
		slow <= 1'b1;
		fail_at <= cnt + 8'h01;
		frsp <= {8'h01, 16'hFF0D, 16'h0000, 1'b0};
		scan(32'h0001_0301);
		chk("requests", cnt - base, 5);
		chk("after fail", u_link.log_q[base + 8'h02].op,
			scpd_pkg::OP_RD_ITEM);
		rd(6'h00, 32'h0000_FF0D);
		slow <= 1'b0;
		wr(6'h01, 32'h0000_0600);
		scan(32'h0001_0301);
		chk("no set_value", u_link.log_q[base].op, scpd_pkg::OP_EXEC);
		chk("requests", cnt - base, 4);
		fail_at <= cnt + 8'h03;
		frsp <= {8'h00, 16'h1100, 16'h0000, 1'b0};
		scan(32'h0004_0001);
		for (int k = 1; k <= 10; k++)
			rd(6'h20 + 6'(k), (k < 3) ? {16'h0000, 16'hF000 + 16'(k)} :
				32'h0000_0000);
		rd(6'h20, 32'h0000_1100);
		for (int i = 0; i < 23; i++) begin
			fail_at <= cnt;
			frsp <= {(codes[i][15:8] == 8'hFF) ? 8'h01 : 8'h00, codes[i],
				16'h0000, 1'b0};
			scan(32'h0001_0001);
			rd(6'h00, {16'h0000, codes[i]});
		end
		fail_at <= cnt;
		frsp <= {8'h00, 16'h0000, 16'h0000, 1'b1};
		scan(32'h0001_0001);
		rd(6'h00, 32'h0000_FFFF);
		rd(scpd_pkg::IDX_STAT, 32'h0000_0000);
		fail_at <= cnt + 8'h03;
		frsp <= {8'h00, 16'h0123, 16'h0000, 1'b0};
		scan(32'h0001_0001);
		rd(6'h20, 32'h0000_0123);
		rd(6'h23, 32'h0000_0000);
		rd(scpd_pkg::IDX_STAT, 32'h0000_0008);
		summarize();
	end

	initial begin
		#1500000;
		errors++;
		summarize();
	end
endmodule
